// File: mrc_cfg.svh
// constants of the monitor reset control block: offsets, fields, resets,
// timing counts; assumes a 50 MHz core clock and an apb word map
`ifndef MRC_CFG_SVH
`define MRC_CFG_SVH
// register indexes: each register takes one aligned word, so the byte
// address on the bus is four times the index
`define MRC_IDX_TRIP_LOCAL 8'h13
`define MRC_IDX_TRIP_REMOTE 8'h14
`define MRC_IDX_TEST 8'h15
`define MRC_IDX_CONFIG 8'h40
`define MRC_IDX_INT_STATUS 8'h41
`define MRC_IDX_INT_MASK 8'h43
`define MRC_IDX_INT_MIRROR 8'h4c
`define MRC_IDX_ANALOG_OUT 8'h19
`define MRC_IDX_RESET_CTRL 8'h50
`define MRC_IDX_RESET_STAT 8'h51
// configuration fields
`define MRC_CFG_SOFT_RESET_BIT 4
`define MRC_CFG_LOCK_BIT 3
// power-on values
`define MRC_RST_CONFIG 8'h25
`define MRC_RST_ZERO 8'h00
`define MRC_RST_TRIP_LOCAL 8'h46
`define MRC_RST_TRIP_REMOTE 8'h64
`define MRC_RST_ANALOG_OUT 8'hff
// timing: reset pulse period in microseconds and clock rate in MHz
`define MRC_PULSE_PERIOD_US 140
`define MRC_CLK_MHZ 50
`define MRC_PULSE_CYCLES (`MRC_PULSE_PERIOD_US * `MRC_CLK_MHZ)
`endif

// File: mrc_pkg.sv
// types of the monitor reset control block
// assumes mrc_cfg.svh gives the numbers
package mrc_pkg;
    // apb request from master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } mrc_apb_req_type;
    // reset sequencer states
    typedef enum logic [2:0] {
        MRC_ST_OFF = 3'b001,
        MRC_ST_HOLD = 3'b010,
        MRC_ST_RUN = 3'b100
    } mrc_state_type;
endpackage

// File: mrc_reset_net.sv
// model of the reset net around the block: pull-ups, push-button, host
// assumes the bench moves btn_press_i and host_pull_i after clock edges
`timescale 1ns/1ns
module mrc_reset_net (
    input wire logic btn_press_i, // push-button held down
    input wire logic host_pull_i, // host pulls the bidir pin low
    input wire logic pin_oe_i, // device drives the bidir pin low
    input wire logic out_oe_i, // device pulls the reset output low
    input wire logic pin_drv_i, // level the device puts on the bidir pin
    input wire logic out_drv_i, // level the device puts on the reset output
    output logic manual_n_o, // manual reset wire with pull-up
    output logic pin_o, // resolved bidir pin wire with pull-up
    output logic sys_rst_n_o // system reset net with pull-up
);
    assign manual_n_o = !btn_press_i; // pull-up when released
    // wired low: host or device, pull-up otherwise
    assign pin_o = !host_pull_i && (pin_oe_i ? pin_drv_i : 1'b1);
    assign sys_rst_n_o = out_oe_i ? out_drv_i : 1'b1; // pull-up when released
endmodule // mrc_reset_net

// File: mrc_reset_properties.sv
// checker of the monitor reset control ports: causes, stretch, gating, apb
// assumes a bind onto mrc_reset_top, one clock domain on REF_CLK_I
`timescale 1ns/1ns
module mrc_reset_properties (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic MANUAL_RESET_IN_N_I,
    input wire logic BIDIR_RESET_PIN_I,
    input wire logic SUPPLY_ABOVE_1V_I,
    input wire logic SUPPLY_OK_I,
    input wire logic MONITORED_SUPPLY_OK_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic BIDIR_RESET_PIN_OE_O,
    input wire logic SYSTEM_RESET_OUT_OE_O,
    input wire logic ENGINE_ENABLE_O
);
    // ****************************************
    // helper: cycles with every cause clear
    // ****************************************
    logic all_clear; // no cause and gate drive present
    logic [13:0] clr_cnt_ff; // saturating count of clear cycles
    assign all_clear = MANUAL_RESET_IN_N_I & BIDIR_RESET_PIN_I & SUPPLY_OK_I
        & MONITORED_SUPPLY_OK_I & SUPPLY_ABOVE_1V_I;
    // restarts on any cause, holds at the top
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            clr_cnt_ff <= 14'h0;
        end else if (!all_clear) begin
            clr_cnt_ff <= 14'h0;
        end else if (clr_cnt_ff != 14'h3fff) begin
            clr_cnt_ff <= clr_cnt_ff + 14'h1;
        end
    end
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // ****************************************
    // apb steps
    // ****************************************
    sequence apb_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence apb_access;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence
    // ****************************************
    // properties
    // ****************************************
    chk_manual_drives_out: assert property (
        (!MANUAL_RESET_IN_N_I && SUPPLY_ABOVE_1V_I)[*5] |-> SYSTEM_RESET_OUT_OE_O)
        else $error("manual reset did not pull the reset output");
    chk_pin_drives_out: assert property (
        (!BIDIR_RESET_PIN_I && SUPPLY_ABOVE_1V_I)[*5] |-> SYSTEM_RESET_OUT_OE_O)
        else $error("low bidir pin did not pull the reset output");
    chk_monitor_drives_out: assert property (
        (!MONITORED_SUPPLY_OK_I && SUPPLY_ABOVE_1V_I)[*5]
        |-> SYSTEM_RESET_OUT_OE_O)
        else $error("monitored supply low did not pull the reset output");
    chk_brownout_pin: assert property (
        (!SUPPLY_OK_I && SUPPLY_ABOVE_1V_I)[*5] |-> BIDIR_RESET_PIN_OE_O)
        else $error("brownout did not drive the bidir pin");
    chk_no_gate_drive: assert property (
        (!SUPPLY_ABOVE_1V_I)[*4]
        |-> !SYSTEM_RESET_OUT_OE_O && !BIDIR_RESET_PIN_OE_O)
        else $error("reset outputs driven without gate drive");
    chk_stretch_min: assert property (
        $fell(SYSTEM_RESET_OUT_OE_O) && SUPPLY_ABOVE_1V_I
        && $past(SUPPLY_ABOVE_1V_I) |-> clr_cnt_ff >= 14'h1b58)
        else $error("reset output released before the pulse period");
    chk_stretch_max: assert property (
        clr_cnt_ff == 14'h1b6c |-> !SYSTEM_RESET_OUT_OE_O)
        else $error("reset output held past the pulse period");
    chk_engine_idle: assert property (
        (!BIDIR_RESET_PIN_I)[*5] |-> !ENGINE_ENABLE_O)
        else $error("engine enabled while bidir pin low");
    chk_apb_answer: assert property (apb_setup |=> apb_access)
        else $error("apb access without ready");
    chk_ready_in_access: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
        else $error("ready outside an access phase");
endmodule // mrc_reset_properties

bind mrc_reset_top mrc_reset_properties u_chk (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
    .MANUAL_RESET_IN_N_I(MANUAL_RESET_IN_N_I),
    .BIDIR_RESET_PIN_I(BIDIR_RESET_PIN_I),
    .SUPPLY_ABOVE_1V_I(SUPPLY_ABOVE_1V_I), .SUPPLY_OK_I(SUPPLY_OK_I),
    .MONITORED_SUPPLY_OK_I(MONITORED_SUPPLY_OK_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O),
    .BIDIR_RESET_PIN_OE_O(BIDIR_RESET_PIN_OE_O),
    .SYSTEM_RESET_OUT_OE_O(SYSTEM_RESET_OUT_OE_O),
    .ENGINE_ENABLE_O(ENGINE_ENABLE_O));

// File: mrc_reset_top.sv
// reset control of a temperature monitor: pins, stretch, register init
// assumes apb master on REF_CLK_I, async pins, comparator levels as inputs
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_reset_top
    import mrc_pkg::*;
(
    input wire logic REF_CLK_I, // core clock, 50 MHz
    input wire logic RST_N_I, // async power-on reset, active low
    input wire logic MANUAL_RESET_IN_N_I, // manual reset pin
    input wire logic BIDIR_RESET_PIN_I, // bidir reset pin level
    input wire logic SUPPLY_ABOVE_1V_I, // supply exceeds gate drive level
    input wire logic SUPPLY_OK_I, // main supply above reset threshold
    input wire logic MONITORED_SUPPLY_OK_I, // monitored supply comparator
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    output logic BIDIR_RESET_PIN_O, // pin output level, always low
    output logic BIDIR_RESET_PIN_OE_O, // high while pin driven low
    output logic SYSTEM_RESET_OUT_N_O, // open-drain level, low when active
    output logic SYSTEM_RESET_OUT_OE_O, // high while output pulled low
    output logic ENGINE_ENABLE_O, // conversion engine may run
    output logic [7:0] ANALOG_OUT_O // analog output register
);

    // ****************************************
    // apb decode helpers
    // ****************************************
    // byte address of a printed index
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'b00, idx, 2'b00};
    endfunction

    mrc_apb_req_type req; // bundled bus request
    assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I,
                   paddr: PADDR_I, pwdata: PWDATA_I};

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [1:0] man_sync_ff; // manual reset sync chain
    logic [1:0] pin_sync_ff; // bidir pin sync chain
    logic [1:0] sup_sync_ff; // main supply sync chain
    logic [1:0] mon_sync_ff; // monitored supply sync chain
    logic [1:0] v1_sync_ff; // gate drive sync chain

    // two flops per async level
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            man_sync_ff <= 2'h3;
            pin_sync_ff <= 2'h3;
            sup_sync_ff <= 2'h0;
            mon_sync_ff <= 2'h0;
            v1_sync_ff <= 2'h0;
        end else begin
            man_sync_ff <= {man_sync_ff[0], MANUAL_RESET_IN_N_I};
            pin_sync_ff <= {pin_sync_ff[0], BIDIR_RESET_PIN_I};
            sup_sync_ff <= {sup_sync_ff[0], SUPPLY_OK_I};
            mon_sync_ff <= {mon_sync_ff[0], MONITORED_SUPPLY_OK_I};
            v1_sync_ff <= {v1_sync_ff[0], SUPPLY_ABOVE_1V_I};
        end
    end

    logic man_low; // manual reset held
    logic pin_low; // bidir pin low from either side
    logic sup_low; // main supply brownout
    logic cause; // any reset cause
    assign man_low = !man_sync_ff[1];
    assign pin_low = !pin_sync_ff[1];
    assign sup_low = !sup_sync_ff[1];
    assign cause = man_low || pin_low || sup_low || !mon_sync_ff[1];

    // ****************************************
    // reset stretch sequencer
    // ****************************************
    localparam logic [15:0] PULSE_CYCLES = 16'(`MRC_PULSE_CYCLES);
    mrc_state_type state_ff; // sequencer state
    mrc_state_type nxt_state;
    logic [15:0] cnt_ff; // stretch counter
    logic [15:0] nxt_cnt;

    // next state: hold while cause, count out the period
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            MRC_ST_OFF: begin
                nxt_cnt = 16'h0;
                if (!cause) begin
                    nxt_state = MRC_ST_HOLD;
                end
            end
            MRC_ST_HOLD: begin
                if (cause) begin
                    nxt_state = MRC_ST_OFF;
                end else if (cnt_ff == PULSE_CYCLES - 16'h1) begin
                    nxt_state = MRC_ST_RUN;
                end else begin
                    nxt_cnt = cnt_ff + 16'h1;
                end
            end
            MRC_ST_RUN: begin
                if (cause) begin
                    nxt_state = MRC_ST_OFF;
                end
            end
            default: nxt_state = MRC_ST_OFF;
        endcase
    end

    // sequencer registers
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_ff <= MRC_ST_OFF;
            cnt_ff <= 16'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    logic sys_rst; // system reset active
    assign sys_rst = (state_ff != MRC_ST_RUN);

    // ****************************************
    // pin drivers
    // ****************************************
    // open-drain outputs, gated by gate drive level
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            SYSTEM_RESET_OUT_OE_O <= 1'b0;
            BIDIR_RESET_PIN_OE_O <= 1'b0;
            ENGINE_ENABLE_O <= 1'b0;
        end else begin
            SYSTEM_RESET_OUT_OE_O <= sys_rst && v1_sync_ff[1];
            BIDIR_RESET_PIN_OE_O <= sup_low && v1_sync_ff[1];
            ENGINE_ENABLE_O <= !sys_rst && !pin_low;
        end
    end
    assign SYSTEM_RESET_OUT_N_O = 1'b0;
    assign BIDIR_RESET_PIN_O = 1'b0;

    // ****************************************
    // register file
    // ****************************************
    logic wr_en; // write takes effect
    logic rd_en; // read access phase
    assign wr_en = req.psel && req.penable && req.pwrite;
    assign rd_en = req.psel && req.penable && !req.pwrite;

    logic hard_init; // power-on style init
    logic soft_init; // soft init pulse
    logic [7:0] config_ff, mask_ff, status_ff, mirror_ff;
    logic [7:0] test_ff, trip_local_ff, trip_remote_ff;
    logic [7:0] reset_ctrl_ff; // bit0: software forces pin-style init
    assign hard_init = sys_rst || reset_ctrl_ff[0];
    assign soft_init = config_ff[`MRC_CFG_SOFT_RESET_BIT];
    // the lock bit survives every init except a system reset
    logic [7:0] lock_keep; // lock bit carried across a non-system init
    assign lock_keep = sys_rst ? 8'h0 :
        (config_ff & (8'h1 << `MRC_CFG_LOCK_BIT));

    // control registers: init on hard or soft reset
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            config_ff <= `MRC_RST_CONFIG;
            mask_ff <= `MRC_RST_ZERO;
            status_ff <= `MRC_RST_ZERO;
            mirror_ff <= `MRC_RST_ZERO;
        end else if (hard_init || soft_init) begin
            config_ff <= `MRC_RST_CONFIG | lock_keep;
            mask_ff <= `MRC_RST_ZERO;
            status_ff <= `MRC_RST_ZERO;
            mirror_ff <= `MRC_RST_ZERO;
        end else if (wr_en && req.paddr == byte_addr(`MRC_IDX_CONFIG)) begin
            // lock bit is write-once: only sets
            config_ff <= req.pwdata[7:0] |
                (config_ff & (8'h1 << `MRC_CFG_LOCK_BIT));
        end else if (wr_en && req.paddr == byte_addr(`MRC_IDX_INT_MASK)) begin
            mask_ff <= req.pwdata[7:0];
        end else if (rd_en && req.paddr == byte_addr(`MRC_IDX_INT_STATUS)) begin
            status_ff <= `MRC_RST_ZERO; // clear on read
        end else if (rd_en && req.paddr == byte_addr(`MRC_IDX_INT_MIRROR)) begin
            mirror_ff <= `MRC_RST_ZERO;
        end
    end

    logic locked; // trip registers locked
    assign locked = config_ff[`MRC_CFG_LOCK_BIT];

    logic trip_init; // system reset always, other inits only unlocked
    assign trip_init = sys_rst || ((reset_ctrl_ff[0] || soft_init) && !locked);

    // trip points: locked data only cleared by system reset
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            trip_local_ff <= `MRC_RST_TRIP_LOCAL;
            trip_remote_ff <= `MRC_RST_TRIP_REMOTE;
        end else if (trip_init) begin
            trip_local_ff <= `MRC_RST_TRIP_LOCAL;
            trip_remote_ff <= `MRC_RST_TRIP_REMOTE;
        end else if (wr_en && !locked) begin
            if (req.paddr == byte_addr(`MRC_IDX_TRIP_LOCAL)) begin
                trip_local_ff <= req.pwdata[7:0];
            end else if (req.paddr == byte_addr(`MRC_IDX_TRIP_REMOTE)) begin
                trip_remote_ff <= req.pwdata[7:0];
            end
        end
    end

    // test and analog: hard init only, soft reset spares them
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            test_ff <= `MRC_RST_ZERO;
            ANALOG_OUT_O <= `MRC_RST_ANALOG_OUT;
        end else if (hard_init) begin
            test_ff <= `MRC_RST_ZERO;
            ANALOG_OUT_O <= `MRC_RST_ANALOG_OUT;
        end else if (wr_en && req.paddr == byte_addr(`MRC_IDX_TEST)) begin
            test_ff <= req.pwdata[7:0];
        end else if (wr_en && req.paddr == byte_addr(`MRC_IDX_ANALOG_OUT)) begin
            ANALOG_OUT_O <= req.pwdata[7:0];
        end
    end

    // software reset control register, not cleared by system reset
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            reset_ctrl_ff <= `MRC_RST_ZERO;
        end else if (wr_en && req.paddr == byte_addr(`MRC_IDX_RESET_CTRL)) begin
            reset_ctrl_ff <= {7'h0, req.pwdata[0]};
        end
    end

    // ****************************************
    // apb read path, zero-wait answer
    // ****************************************
    logic [7:0] rd_mux; // selected read byte
    logic rd_hit; // address mapped
    // value and limit registers are not held here
    always_comb begin
        rd_mux = 8'h0;
        rd_hit = 1'b1;
        if (req.paddr == byte_addr(`MRC_IDX_CONFIG)) begin
            rd_mux = config_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_INT_STATUS)) begin
            rd_mux = status_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_INT_MASK)) begin
            rd_mux = mask_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_INT_MIRROR)) begin
            rd_mux = mirror_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_TEST)) begin
            rd_mux = test_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_TRIP_LOCAL)) begin
            rd_mux = trip_local_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_TRIP_REMOTE)) begin
            rd_mux = trip_remote_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_ANALOG_OUT)) begin
            rd_mux = ANALOG_OUT_O;
        end else if (req.paddr == byte_addr(`MRC_IDX_RESET_CTRL)) begin
            rd_mux = reset_ctrl_ff;
        end else if (req.paddr == byte_addr(`MRC_IDX_RESET_STAT)) begin
            rd_mux = {3'h0, mon_sync_ff[1], sup_sync_ff[1], pin_low, man_low,
                      sys_rst};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // registered answer: pready in the first cycle of the access phase
    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h0;
        end else begin
            PREADY_O <= req.psel && !req.penable;
            PSLVERR_O <= req.psel && !req.penable && !rd_hit;
            PRDATA_O <= {24'h0, rd_mux};
        end
    end

endmodule // mrc_reset_top

// File: mrc_reset_top_tb_top.sv
// self-checking bench of the monitor reset control block
// assumes the design files, the reset net model and the bound checker
`timescale 1ns/1ns
`include "mrc_cfg.svh"
module mrc_reset_top_tb_top
    import mrc_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, s1v = 1'b1, sok = 1'b1, mok = 1'b1;
    logic btn = 1'b0, hpull = 1'b0; // partner controls
    mrc_apb_req_type req = '0; // apb request bundle
    logic [31:0] prdata;
    logic pready, pslverr, pin_oe, out_oe, eng, man_n, pin_lvl, sys_n;
    logic pin_drv, sys_drv; // levels the device puts on its pins
    logic [7:0] aout;
    int fail_count = 0, n_compared = 0;
    always #10 clk = ~clk; // 50 MHz
    mrc_reset_net u_net (.btn_press_i(btn), .host_pull_i(hpull),
        .pin_oe_i(pin_oe), .out_oe_i(out_oe), .pin_drv_i(pin_drv),
        .out_drv_i(sys_drv), .manual_n_o(man_n),
        .pin_o(pin_lvl), .sys_rst_n_o(sys_n));
    mrc_reset_top u_dut (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .MANUAL_RESET_IN_N_I(man_n), .BIDIR_RESET_PIN_I(pin_lvl),
        .SUPPLY_ABOVE_1V_I(s1v), .SUPPLY_OK_I(sok),
        .MONITORED_SUPPLY_OK_I(mok), .PSEL_I(req.psel),
        .PENABLE_I(req.penable), .PWRITE_I(req.pwrite), .PADDR_I(req.paddr),
        .PWDATA_I(req.pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .BIDIR_RESET_PIN_O(pin_drv),
        .BIDIR_RESET_PIN_OE_O(pin_oe), .SYSTEM_RESET_OUT_N_O(sys_drv),
        .SYSTEM_RESET_OUT_OE_O(out_oe), .ENGINE_ENABLE_O(eng),
        .ANALOG_OUT_O(aout));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_sim();
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [7:0] ix,
        input logic [7:0] d, output logic [31:0] r, output logic e);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, {2'h0, ix, 2'h0}, {24'h0, d}};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, ix, d, r, e);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, ix, 8'h00, r, e);
        chk(r, {24'h0, x});
    endtask
    // output held a pulse period, then released
    task automatic stretch();
        int n;
        repeat (6990) @(posedge clk);
        chk(out_oe, 1'b1);
        chk(sys_n, 1'b0);
        n = 0;
        while (out_oe !== 1'b0 && n < 100) begin @(posedge clk); n++; end
        chk(out_oe, 1'b0);
        chk(sys_n, 1'b1);
        repeat (2) @(posedge clk);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_power_up();
        logic [7:0] ix [9] = '{`MRC_IDX_CONFIG, `MRC_IDX_INT_STATUS,
            `MRC_IDX_INT_MASK, `MRC_IDX_INT_MIRROR, `MRC_IDX_TEST,
            `MRC_IDX_ANALOG_OUT, `MRC_IDX_TRIP_LOCAL, `MRC_IDX_TRIP_REMOTE,
            8'h42};
        logic [7:0] x [9] = '{8'h25, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff,
            8'h46, 8'h64, 8'h00};
        logic [31:0] r;
        logic e;
        repeat (6) @(posedge clk);
        stretch();
        chk(eng, 1'b1);
        for (int i = 0; i < 9; i++) rd(ix[i], x[i]);
        rd(`MRC_IDX_RESET_STAT, 8'h18);
        apb(1'b0, 8'h42, 8'h00, r, e);
        chk(e, 1'b1); // unmapped place refused
        chk(aout, 8'hff);
    endtask
    task automatic t_soft();
        wr(`MRC_IDX_TEST, 8'h3c);
        wr(`MRC_IDX_ANALOG_OUT, 8'h5a);
        wr(`MRC_IDX_INT_MASK, 8'h0f);
        wr(`MRC_IDX_TRIP_LOCAL, 8'h11);
        wr(`MRC_IDX_CONFIG, 8'h35);
        rd(`MRC_IDX_CONFIG, 8'h25);
        rd(`MRC_IDX_INT_MASK, 8'h00);
        rd(`MRC_IDX_TRIP_LOCAL, 8'h46);
        rd(`MRC_IDX_TEST, 8'h3c);
        rd(`MRC_IDX_ANALOG_OUT, 8'h5a);
        chk(aout, 8'h5a);
        wr(`MRC_IDX_RESET_CTRL, 8'h01);
        wr(`MRC_IDX_INT_MASK, 8'h0f);
        rd(`MRC_IDX_INT_MASK, 8'h00);
        rd(`MRC_IDX_RESET_CTRL, 8'h01);
        chk(aout, 8'hff);
        wr(`MRC_IDX_RESET_CTRL, 8'h00);
    endtask
    task automatic t_lock_manual();
        wr(`MRC_IDX_TRIP_LOCAL, 8'h33);
        wr(`MRC_IDX_CONFIG, 8'h2d);
        wr(`MRC_IDX_TRIP_LOCAL, 8'h22);
        rd(`MRC_IDX_TRIP_LOCAL, 8'h33);
        wr(`MRC_IDX_CONFIG, 8'h3d);
        rd(`MRC_IDX_CONFIG, 8'h2d);
        rd(`MRC_IDX_TRIP_LOCAL, 8'h33);
        wr(`MRC_IDX_INT_MASK, 8'h0f);
        btn <= 1'b1;
        repeat (6) @(posedge clk);
        chk(out_oe, 1'b1);
        btn <= 1'b0;
        stretch();
        rd(`MRC_IDX_INT_MASK, 8'h00);
        rd(`MRC_IDX_ANALOG_OUT, 8'hff);
        rd(`MRC_IDX_TRIP_LOCAL, 8'h46);
        wr(`MRC_IDX_TRIP_LOCAL, 8'h22);
        rd(`MRC_IDX_TRIP_LOCAL, 8'h22);
    endtask
    task automatic t_pin_in();
        hpull <= 1'b1;
        repeat (6) @(posedge clk);
        chk(eng, 1'b0);
        chk(out_oe, 1'b1);
        hpull <= 1'b0;
        stretch();
    endtask
    task automatic t_supplies();
        sok <= 1'b0;
        repeat (6) @(posedge clk);
        chk(pin_oe, 1'b1);
        chk(pin_lvl, 1'b0);
        chk(out_oe, 1'b1);
        sok <= 1'b1;
        stretch();
        mok <= 1'b0;
        repeat (6) @(posedge clk);
        chk({pin_oe, out_oe}, 2'b01);
        mok <= 1'b1;
        stretch();
        s1v <= 1'b0;
        btn <= 1'b1;
        repeat (6) @(posedge clk);
        chk({pin_oe, out_oe}, 2'b00);
        s1v <= 1'b1;
        repeat (6) @(posedge clk);
        chk(out_oe, 1'b1);
        btn <= 1'b0;
        stretch();
    endtask
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_soft();
        t_lock_manual();
        t_pin_in();
        t_supplies();
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule // mrc_reset_top_tb_top
